/* File: scosc_cfg.svh */
// Purpose: constants for the subsystem oscillator and cpu clock select block
// Assumes: byte-wide special register space, 16-bit addresses
// Notes: offsets, field positions, reset values and timing counts
`ifndef SCOSC_CFG_SVH
`define SCOSC_CFG_SVH
`define SCOSC_ADDR_CSSEL 16'hFFF2
`define SCOSC_ADDR_SOMODE 16'hFFF3
`define SCOSC_ADDR_PCR 16'hFFFB
`define SCOSC_SOMODE_RST 8'h00
`define SCOSC_CSSEL_RST 8'h00
`define SCOSC_PCR_RST 8'h02
`define SCOSC_BIT_SUBSTOP 0
`define SCOSC_BIT_FBRES 1
`define SCOSC_BIT_OSCSEL 4
`define SCOSC_BIT_STATUS 5
`define SCOSC_BIT_DIV 1
`define SCOSC_BIT_MAINSTOP 7
`define SCOSC_MAIN_DIV 4
`define SCOSC_SUB_DIV 2
`define SCOSC_HOLD_INSTR 2
`endif

/* File: scosc_pkg.sv */
// Purpose: types for the subsystem oscillator and cpu clock select block
// Assumes: scosc_cfg.svh holds the numbers
// Notes: the cpu bus request travels as one packed struct
package scosc_pkg;
	// one cpu access to the special register space
	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_idx;
		logic [15:0] addr;
		logic [7:0] wdata;
	} scosc_req_t;
	// cpu clock sources
	typedef enum logic [1:0] {SCOSC_SRC_MAIN, SCOSC_SRC_MAIN4, SCOSC_SRC_SUB2} scosc_src_t;
endpackage

/* File: scosc_glitchless.sv */
// Purpose: glitch free switch between two clock-enable sources
// Assumes: both sources are one-cycle enables on mclk
// Notes: the old source runs out a hold count before the new one takes over
`timescale 1ns/1ps
`include "scosc_cfg.svh"
module scosc_glitchless
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic en_a,
	input wire logic en_b,
	input wire logic want_b,
	output logic en_out,
	output logic on_b
);
	// edges of the old source already run while a change waits to hand over
	logic [3:0] hold;
	wire logic cur_en = on_b ? en_b : en_a;
	wire logic change = want_b != on_b;
	// hand over only on an old-source edge, so no pulse is ever cut short
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			on_b <= 1'b0;
			hold <= 4'h0;
			en_out <= 1'b0;
		end
		else
		begin
			en_out <= cur_en;
			if (!change)
				hold <= 4'h0;
			else if (cur_en)
			begin
				// old clock kept for a few instructions
				if (hold == 4'(`SCOSC_HOLD_INSTR * 2 - 1))
				begin
					on_b <= want_b;
					hold <= 4'h0;
				end
				else
					hold <= hold + 4'h1;
			end
		end
	end
endmodule

/* File: scosc_top.sv */
// Purpose: cpu clock source select, oscillator control and standby gating
// Assumes: cpu accesses are single-cycle strobes on mclk; oscillator clocks arrive as pins
// Notes: cpu clock and peripheral clocks leave as one-cycle enables on mclk
`timescale 1ns/1ps
`include "scosc_cfg.svh"
module scosc_top
(
	input wire logic mclk,
	input wire logic rstn,
	input wire scosc_pkg::scosc_req_t req,
	input wire logic stop_req,
	input wire logic halt_req,
	input wire logic main_osc_pin,
	input wire logic sub_osc_pin,
	output logic [7:0] rdata,
	output logic main_osc_en,
	output logic sub_osc_en,
	output logic fb_res_en,
	output logic cpu_clk_en,
	output logic sub_periph_en,
	output logic main_periph_en,
	output logic stop_grant,
	output logic halt_grant,
	output logic cpu_on_sub
);
	import scosc_pkg::*;
	// register state
	logic [7:0] sub_oscillator_mode;
	logic oscillator_select;
	logic cpu_clock_divide;
	logic main_oscillator_stop;
	// pin synchronisers, stage one read only by stage two
	logic main_s1, main_s2, main_s3;
	logic sub_s1, sub_s2, sub_s3;
	logic [1:0] div4;
	logic sub_half;
	logic on_sub;
	logic mux_en;
	// address decode and write data with bit merge
	wire logic hit_mode = req.addr == `SCOSC_ADDR_SOMODE;
	wire logic hit_sel = req.addr == `SCOSC_ADDR_CSSEL;
	wire logic hit_pcr = req.addr == `SCOSC_ADDR_PCR;
	wire logic [7:0] bit_mask = 8'h01 << req.bit_idx;
	wire logic [7:0] sel_now = {2'b00, on_sub, oscillator_select, 4'h0};
	wire logic [7:0] pcr_now = {main_oscillator_stop, 5'h00, cpu_clock_divide, 1'b0};
	// single-bit writes merge into the current byte
	wire logic [7:0] mode_w = req.bit_op ?
		((sub_oscillator_mode & ~bit_mask) | (req.wdata & bit_mask)) : req.wdata;
	wire logic [7:0] sel_w = req.bit_op ? ((sel_now & ~bit_mask) | (req.wdata & bit_mask)) : req.wdata;
	wire logic [7:0] pcr_w = req.bit_op ? ((pcr_now & ~bit_mask) | (req.wdata & bit_mask)) : req.wdata;
	// edges of synchronised oscillator pins
	wire logic main_edge = main_s2 & ~main_s3;
	wire logic sub_edge = sub_s2 & ~sub_s3;
	wire logic main_run = !main_oscillator_stop;
	// main/4 and sub/2 enables
	wire logic main_tick = main_edge & main_run;
	wire logic main4_tick = main_tick & (div4 == 2'(`SCOSC_MAIN_DIV - 1));
	wire logic main_src = cpu_clock_divide ? main4_tick : main_tick;
	wire logic sub_tick = sub_edge & !sub_oscillator_mode[`SCOSC_BIT_SUBSTOP];
	wire logic sub2_tick = sub_tick & sub_half;
	wire logic [7:0] next_rdata = hit_mode ? sub_oscillator_mode :
		hit_sel ? sel_now : hit_pcr ? pcr_now : 8'h00;
	// register writes
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sub_oscillator_mode <= `SCOSC_SOMODE_RST;
			oscillator_select <= 1'b0;
			cpu_clock_divide <= 1'b1;
			main_oscillator_stop <= 1'b0;
		end
		else if (req.wr)
		begin
			if (hit_mode)
				sub_oscillator_mode <= mode_w;
			if (hit_sel)
				oscillator_select <= sel_w[`SCOSC_BIT_OSCSEL]; // status bit ignored
			if (hit_pcr)
			begin
				cpu_clock_divide <= pcr_w[`SCOSC_BIT_DIV];
				// main stop taken only while subsystem clock is cpu clock
				if (on_sub)
					main_oscillator_stop <= pcr_w[`SCOSC_BIT_MAINSTOP];
			end
		end
	end
	// synchronisers and dividers
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			main_s1 <= 1'b0;
			main_s2 <= 1'b0;
			main_s3 <= 1'b0;
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
			div4 <= 2'h0;
			sub_half <= 1'b0;
		end
		else
		begin
			main_s1 <= main_osc_pin;
			main_s2 <= main_s1;
			main_s3 <= main_s2;
			sub_s1 <= sub_osc_pin;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
			if (main_tick)
				div4 <= div4 + 2'h1;
			if (sub_tick)
				sub_half <= ~sub_half;
		end
	end
	// glitch free switch between main and subsystem sources
	scosc_glitchless u_sw
	(
		.mclk(mclk),
		.rstn(rstn),
		.en_a(main_src),
		.en_b(sub2_tick),
		.want_b(oscillator_select),
		.en_out(mux_en),
		.on_b(on_sub)
	);
	// registered outputs
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata <= 8'h00;
			main_osc_en <= 1'b0;
			sub_osc_en <= 1'b0;
			fb_res_en <= 1'b0;
			cpu_clk_en <= 1'b0;
			sub_periph_en <= 1'b0;
			main_periph_en <= 1'b0;
			stop_grant <= 1'b0;
			halt_grant <= 1'b0;
			cpu_on_sub <= 1'b0;
		end
		else
		begin
			rdata <= req.rd ? next_rdata : 8'h00;
			main_osc_en <= main_run;
			sub_osc_en <= !sub_oscillator_mode[`SCOSC_BIT_SUBSTOP];
			fb_res_en <= !sub_oscillator_mode[`SCOSC_BIT_FBRES];
			cpu_clk_en <= mux_en;
			sub_periph_en <= sub_tick;
			main_periph_en <= main_tick;
			stop_grant <= stop_req & !on_sub;
			halt_grant <= halt_req;
			cpu_on_sub <= on_sub;
		end
	end
	// read data and status both zero as reset releases
	a_reset_state: assert property (@(posedge mclk) $rose(rstn) |-> rdata == 8'h00 && !cpu_on_sub)
		else $error("reset state wrong");
	a_stop_on_sub: assert property (@(posedge mclk) disable iff (!rstn)
		stop_grant |-> $past(!on_sub))
		else $error("stop granted on subclock");
	a_stop_main: assert property (@(posedge mclk) disable iff (!rstn)
		stop_req && !on_sub |=> stop_grant)
		else $error("stop refused on main");
	a_halt_pass: assert property (@(posedge mclk) disable iff (!rstn)
		halt_req |=> halt_grant)
		else $error("halt refused");
	a_fb_res: assert property (@(posedge mclk) disable iff (!rstn)
		req.wr && hit_mode && !req.bit_op |=> ##1 fb_res_en == !$past(req.wdata[1], 2))
		else $error("feedback select wrong");
	a_sub_stop: assert property (@(posedge mclk) disable iff (!rstn)
		req.wr && hit_mode && !req.bit_op |=> ##1 sub_osc_en == !$past(req.wdata[0], 2))
		else $error("sub stop wrong");
	a_mstop_guard: assert property (@(posedge mclk) disable iff (!rstn)
		!on_sub && !main_oscillator_stop |=> !main_oscillator_stop)
		else $error("main stopped while on main");
	a_sub_periph: assert property (@(posedge mclk) disable iff (!rstn)
		sub_periph_en |-> $past(sub_edge))
		else $error("sub peripheral tick unsourced");
	a_status_rd: assert property (@(posedge mclk) disable iff (!rstn)
		req.rd && hit_sel |=> rdata[5] == cpu_on_sub && rdata[7:6] == 2'b00)
		else $error("status read wrong");
endmodule

/* File: scosc_osc_model.sv */
// Purpose: oscillator pins feeding the clock block
// Assumes: a pin toggles only while its oscillator enable is high
// Notes: a stopped oscillator parks its pin low
`timescale 1ns/1ps
module scosc_osc_model
(
	input wire logic mclk,
	input wire logic main_run,
	input wire logic sub_run,
	output logic main_pin,
	output logic sub_pin
);
	int cnt; // free-running phase counter
	initial
	begin
		cnt = 0;
		main_pin = 1'b0;
		sub_pin = 1'b0;
	end
	// main pin: period 4 cycles; sub pin: period 40 cycles
	always @(posedge mclk)
	begin
		cnt <= cnt + 1;
		if (!main_run)
			main_pin <= 1'b0;
		else if (cnt[0])
			main_pin <= ~main_pin;
		if (!sub_run)
			sub_pin <= 1'b0;
		else if (cnt % 20 == 0)
			sub_pin <= ~sub_pin;
	end
endmodule

/* File: test_subclock_oscillator_and_cpu_clock_select.sv */
// Purpose: self-checking bench for the cpu clock select block
// Assumes: registers reached by single-cycle strobes on mclk
// Notes: reference registers held as integers in the bench
`timescale 1ns/1ps
module test_subclock_oscillator_and_cpu_clock_select;
	import scosc_pkg::*;
	logic mclk, rstn, stop_req, halt_req, mpin, spin;
	scosc_req_t req;
	logic [7:0] rdata;
	logic mosc, sosc, fbres, cpu_en, sub_pe, main_pe, stop_g, halt_g, on_sub;
	int mismatches, checks, n_sub, n_main, n_cpu, mode_m;
	logic [7:0] rd_q; // read data caught in the one cycle that it stands
	scosc_top uut (.mclk(mclk), .rstn(rstn), .req(req), .stop_req(stop_req),
		.halt_req(halt_req), .main_osc_pin(mpin), .sub_osc_pin(spin), .rdata(rdata),
		.main_osc_en(mosc), .sub_osc_en(sosc), .fb_res_en(fbres), .cpu_clk_en(cpu_en),
		.sub_periph_en(sub_pe), .main_periph_en(main_pe), .stop_grant(stop_g),
		.halt_grant(halt_g), .cpu_on_sub(on_sub));
	scosc_osc_model osc (.mclk(mclk), .main_run(mosc), .sub_run(sosc), .main_pin(mpin),
		.sub_pin(spin));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// count peripheral and cpu enable pulses
	always @(posedge mclk)
	begin
		n_sub += (sub_pe === 1'b1);
		n_main += (main_pe === 1'b1);
		n_cpu += (cpu_en === 1'b1);
	end
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
	begin
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	end
	endtask
	// one register access; read data is caught in rd_q
	task acc(input logic w, input logic b, input logic [2:0] i, input logic [15:0] a,
		input logic [7:0] d);
	begin
		req = '{wr: w, rd: ~w, bit_op: b, bit_idx: i, addr: a, wdata: d};
		@(posedge mclk) #1;
		req = '0;
		rd_q = rdata; // read data stands only until the next edge
		repeat (2) @(posedge mclk) #1;
	end
	endtask
	// clear the pulse counters and let a window of cycles run
	task count_win(input int cyc);
	begin
		n_sub = 0;
		n_main = 0;
		n_cpu = 0;
		repeat (cyc) @(posedge mclk) #1;
	end
	endtask
	// bounded wait for the status level
	task wait_sub(input logic want);
		int k;
	begin
		for (k = 0; k < 3000 && on_sub !== want; k++)
			@(posedge mclk) #1;
		chk({7'h00, on_sub}, {7'h00, want}, "switch timeout");
		if (on_sub !== want)
			end_of_test();
	end
	endtask
	initial
	begin
		rstn = 1'b0;
		req = '0;
		stop_req = 1'b0;
		halt_req = 1'b0;
		void'($urandom(16426));
		repeat (3) @(posedge mclk) #1;
		rstn = 1'b1;
		repeat (2) @(posedge mclk) #1;
		chk({5'h00, mosc, sosc, fbres}, 8'h07, "enables after reset");
		req = '{wr: 1'b0, rd: 1'b1, bit_op: 1'b0, bit_idx: 3'h0, addr: 16'hFFF2, wdata: 8'h00};
		@(posedge mclk) #1;
		req = '0;
		chk(rdata, 8'h00, "select reset");
		acc(1'b0, 1'b0, 3'h0, 16'hFFFB, 8'h00);
		chk(rd_q, 8'h02, "processor clock reset");
		acc(1'b0, 1'b0, 3'h0, 16'hFFF0, 8'h00);
		chk(rd_q, 8'h00, "unmapped read");
		for (int k = 0; k < 6; k++)
		begin
			// random feedback and stop bits, upper bits kept zero
			mode_m = $urandom & 3;
			acc(1'b1, 1'b0, 3'h0, 16'hFFF3, mode_m[7:0]);
			chk({6'h00, fbres, sosc}, {6'h00, ~mode_m[1:0]}, "mode outputs");
			acc(1'b0, 1'b0, 3'h0, 16'hFFF3, 8'h00);
			chk(rd_q, mode_m[7:0], "mode readback");
		end
		acc(1'b1, 1'b0, 3'h0, 16'hFFF3, 8'h00);
		acc(1'b1, 1'b1, 3'h1, 16'hFFF3, 8'h02);
		chk({6'h00, fbres, sosc}, 8'h01, "bit write");
		acc(1'b1, 1'b1, 3'h1, 16'hFFF3, 8'h00);
		acc(1'b1, 1'b0, 3'h0, 16'hFFF2, 8'h20);
		chk({7'h00, on_sub}, 8'h00, "status write");
		acc(1'b0, 1'b0, 3'h0, 16'hFFF2, 8'h00);
		chk(rd_q, 8'h00, "status write readback");
		stop_req = 1'b1;
		halt_req = 1'b1;
		repeat (2) @(posedge mclk) #1;
		chk({6'h00, stop_g, halt_g}, 8'h03, "grants on main");
		// main pin period 4 cycles: 160 cycles hold 40 main ticks, slow cpu one in four
		count_win(160);
		chk(n_main[7:0], 8'h28, "main peripheral rate");
		chk(n_cpu[7:0], 8'h0A, "slow main cpu rate");
		acc(1'b1, 1'b0, 3'h0, 16'hFFFB, 8'h00);
		count_win(160);
		chk(n_cpu[7:0], 8'h28, "fast main cpu rate");
		acc(1'b1, 1'b0, 3'h0, 16'hFFFB, 8'h02);
		acc(1'b1, 1'b1, 3'h4, 16'hFFF2, 8'h10);
		chk({7'h00, on_sub}, 8'h00, "old clock kept");
		wait_sub(1'b1);
		acc(1'b0, 1'b0, 3'h0, 16'hFFF2, 8'h00);
		chk(rd_q, 8'h30, "select status");
		chk({6'h00, stop_g, halt_g}, 8'h01, "grants on sub");
		acc(1'b1, 1'b0, 3'h0, 16'hFFFB, 8'h82);
		// sub pin period 40 cycles: 240 cycles hold 6 sub ticks, cpu one in two
		count_win(240);
		chk({7'h00, mosc}, 8'h00, "main stopped");
		chk(n_main[7:0], 8'h00, "main peripherals halted");
		chk(n_sub[7:0], 8'h06, "sub peripherals run");
		chk(n_cpu[7:0], 8'h03, "sub cpu rate");
		acc(1'b1, 1'b0, 3'h0, 16'hFFFB, 8'h02);
		acc(1'b1, 1'b0, 3'h0, 16'hFFF2, 8'h00);
		wait_sub(1'b0);
		end_of_test();
	end
endmodule
